// ===== src/uidr_top.sv
/*
 * Interrupt prioritisation, interrupt clearing and DMA ready pins of one UART channel,
 * with an Avalon-MM slave for its registers.
 * Assumes the FIFO datapath, flow control and receiver run on clk_i and report counts,
 * status bits and one-cycle event pulses; only the CTS pin arrives asynchronously.
 */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module uidr_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [uidr_pkg::CNT_W-1:0] rx_count_i,
    input wire logic [uidr_pkg::CNT_W-1:0] tx_count_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [3:0] line_err_i,
    input wire logic [3:0] modem_bits_i,
    input wire logic rx_char_i,
    input wire logic bit_tick_i,
    input wire logic xoff_det_i,
    input wire logic special_det_i,
    input wire logic xon_det_i,
    input wire logic auto_cts_i,
    input wire logic auto_rts_i,
    input wire logic cts_i,
    input wire logic rts_i,
    output logic irq_o,
    output logic rx_dma_request_n_o,
    output logic tx_dma_request_n_o,
    output logic rx_pop_o,
    output logic tx_push_o,
    output logic [7:0] tx_data_o,
    output logic [7:0] fifo_control_o
);
    // **********************************************************************
    // Bus slave: every access waits one cycle, then completes
    // **********************************************************************
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] ier_q;
    logic [7:0] fcr_q;
    logic [5:0] frozen_q;
    logic [5:0] code;
    wire req = avs_read_i | avs_write_i;
    wire [2:0] idx = avs_address_i[4:2];
    wire rd_done = avs_read_i & ack_q;
    wire wr_done = avs_write_i & ack_q & avs_byteenable_i[0];
    wire rd_data = rd_done & (idx == uidr_pkg::IDX_DATA);
    wire rd_iir = rd_done & (idx == uidr_pkg::IDX_IIR_FCR);
    wire rd_lsr = rd_done & (idx == uidr_pkg::IDX_LSR);
    wire rd_msr = rd_done & (idx == uidr_pkg::IDX_MSR);
    wire wr_thr = wr_done & (idx == uidr_pkg::IDX_DATA);
    wire wr_ier = wr_done & (idx == uidr_pkg::IDX_IER);
    wire wr_fcr = wr_done & (idx == uidr_pkg::IDX_IIR_FCR);
    wire fifo_en = fcr_q[uidr_pkg::FCR_FIFO_EN];
    wire burst = fifo_en & fcr_q[uidr_pkg::FCR_DMA_MODE];
    wire rx_any = rx_count_i != '0;
    wire tx_empty = tx_count_i == '0;
    wire [7:0] lsr_view = {1'b0, tx_empty, tx_empty, line_err_i, rx_any};
    logic [7:0] rsel;
    // Ident read returns the code caught on the first cycle of the access
    always_comb
    begin
        rsel = 8'h00;
        case (idx)
            uidr_pkg::IDX_DATA: rsel = rx_data_i;
            uidr_pkg::IDX_IER: rsel = ier_q;
            uidr_pkg::IDX_IIR_FCR: rsel = {fifo_en, fifo_en, code};
            uidr_pkg::IDX_LSR: rsel = lsr_view;
            uidr_pkg::IDX_MSR: rsel = {4'h0, modem_bits_i};
            default: rsel = 8'h00;
        endcase
    end
    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o = rdata_q;
    assign fifo_control_o = fcr_q;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            frozen_q <= uidr_pkg::CODE_NONE;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (avs_read_i & ~ack_q)
            begin
                rdata_q <= {24'h00_0000, rsel};
                frozen_q <= code;
            end
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ier_q <= uidr_pkg::IER_RESET;
            fcr_q <= uidr_pkg::FCR_RESET;
            rx_pop_o <= 1'b0;
            tx_push_o <= 1'b0;
            tx_data_o <= 8'h00;
        end
        else
        begin
            rx_pop_o <= rd_data;
            tx_push_o <= wr_thr;
            if (wr_thr)
            begin
                tx_data_o <= avs_writedata_i[7:0];
            end
            if (wr_ier)
            begin
                ier_q <= avs_writedata_i[7:0];
            end
            if (wr_fcr)
            begin
                fcr_q <= avs_writedata_i[7:0];
            end
        end
    end
    // **********************************************************************
    // Trigger levels for the fitted FIFO variant
    // **********************************************************************
    logic [uidr_pkg::CNT_W-1:0] rx_trig;
    logic [uidr_pkg::CNT_W-1:0] tx_thr;
    wire [1:0] rx_sel = fcr_q[uidr_pkg::FCR_RXTRIG_LO +: 2];
    wire [1:0] tx_sel = fcr_q[uidr_pkg::FCR_TXTRIG_LO +: 2];
    generate
        if (uidr_pkg::FIFO_DEPTH == 16)
        begin : g_d16
            assign rx_trig = (rx_sel == 2'h3) ? uidr_pkg::RXT16_3 :
                             (rx_sel == 2'h2) ? uidr_pkg::RXT16_2 :
                             (rx_sel == 2'h1) ? uidr_pkg::RXT16_1 : uidr_pkg::RXT16_0;
            assign tx_thr = uidr_pkg::DEPTH_CNT;
        end
        else
        begin : g_d64
            assign rx_trig = (rx_sel == 2'h3) ? uidr_pkg::RXT64_3 :
                             (rx_sel == 2'h2) ? uidr_pkg::RXT64_2 :
                             (rx_sel == 2'h1) ? uidr_pkg::RXT64_1 : uidr_pkg::RXT64_0;
            assign tx_thr = (tx_sel == 2'h3) ? uidr_pkg::TXT64_3 :
                            (tx_sel == 2'h2) ? uidr_pkg::TXT64_2 :
                            (tx_sel == 2'h1) ? uidr_pkg::TXT64_1 : uidr_pkg::TXT64_0;
        end
    endgenerate
    wire [uidr_pkg::CNT_W-1:0] tx_free = uidr_pkg::DEPTH_CNT - tx_count_i;
    wire tx_room = (uidr_pkg::FIFO_DEPTH == 16) ? tx_empty : (tx_free > tx_thr);
    // Without FIFOs a single held character counts as reaching the trigger
    wire rx_at_trig = fifo_en ? (rx_count_i >= rx_trig) : rx_any;
    // **********************************************************************
    // Receive idle timer, counted in bit times
    // **********************************************************************
    logic [uidr_pkg::TO_W-1:0] idle_q;
    logic to_q;
    wire idle_hit = idle_q == uidr_pkg::TIMEOUT_BITS;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            idle_q <= '0;
            to_q <= 1'b0;
        end
        else
        begin
            if (!fifo_en || !rx_any || rx_char_i || rd_data)
            begin
                idle_q <= '0;
            end
            else if (bit_tick_i && !idle_hit)
            begin
                idle_q <= idle_q + 1'b1;
            end
            if (idle_hit && bit_tick_i && fifo_en && rx_any && !rx_char_i)
            begin
                to_q <= 1'b1;
            end
            else if (rd_data)
            begin
                to_q <= 1'b0;
            end
        end
    end
    // **********************************************************************
    // Sticky sources; a set in the clearing cycle wins
    // **********************************************************************
    logic cts_meta_q;
    logic cts_sync_q;
    logic cts_prev_q;
    logic rts_prev_q;
    logic [3:0] err_prev_q;
    logic [3:0] modem_prev_q;
    logic tx_empty_prev_q;
    logic lsr_q;
    logic thre_q;
    logic msr_q;
    logic xoff_q;
    logic special_q;
    logic cts_q;
    logic rts_q;
    wire err_new = |(line_err_i & ~err_prev_q);
    wire thre_set = tx_empty & ~tx_empty_prev_q;
    wire msr_set = modem_bits_i != modem_prev_q;
    wire xoff_set = xoff_det_i | special_det_i;
    wire xoff_clr = rd_iir | xon_det_i | (special_q & rx_char_i);
    wire cts_set = auto_cts_i & cts_sync_q & ~cts_prev_q;
    wire rts_set = auto_rts_i & rts_i & ~rts_prev_q;
    wire flow_clr = rd_iir | rd_msr;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cts_meta_q <= 1'b0;
            cts_sync_q <= 1'b0;
            cts_prev_q <= 1'b0;
            rts_prev_q <= 1'b0;
            err_prev_q <= 4'h0;
            modem_prev_q <= 4'h0;
            tx_empty_prev_q <= 1'b0;
        end
        else
        begin
            cts_meta_q <= cts_i;
            cts_sync_q <= cts_meta_q;
            cts_prev_q <= cts_sync_q;
            rts_prev_q <= rts_i;
            err_prev_q <= line_err_i;
            modem_prev_q <= modem_bits_i;
            tx_empty_prev_q <= tx_empty;
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lsr_q <= 1'b0;
            thre_q <= 1'b0;
            msr_q <= 1'b0;
            xoff_q <= 1'b0;
            special_q <= 1'b0;
            cts_q <= 1'b0;
            rts_q <= 1'b0;
        end
        else
        begin
            lsr_q <= err_new | (lsr_q & ~rd_lsr);
            thre_q <= thre_set | (thre_q & ~(rd_iir | wr_thr));
            msr_q <= msr_set | (msr_q & ~rd_msr);
            xoff_q <= xoff_set | (xoff_q & ~xoff_clr);
            if (xoff_set)
            begin
                special_q <= special_det_i;
            end
            cts_q <= cts_set | (cts_q & ~flow_clr);
            rts_q <= rts_set | (rts_q & ~flow_clr);
        end
    end
    // **********************************************************************
    // Priority, freeze and interrupt output
    // **********************************************************************
    wire [6:0] pend;
    wire [5:0] live_code;
    assign pend[0] = lsr_q & ier_q[uidr_pkg::IER_LSR];
    assign pend[1] = to_q & ier_q[uidr_pkg::IER_RXDATA];
    assign pend[2] = rx_at_trig & ier_q[uidr_pkg::IER_RXDATA];
    assign pend[3] = thre_q & ier_q[uidr_pkg::IER_THRE];
    assign pend[4] = msr_q & ier_q[uidr_pkg::IER_MSR];
    assign pend[5] = xoff_q & ier_q[uidr_pkg::IER_XOFF];
    assign pend[6] = (cts_q & ier_q[uidr_pkg::IER_CTS]) | (rts_q & ier_q[uidr_pkg::IER_RTS]);
    wire pend_any = |pend;
    uidr_prio u_prio (
        .pend_i(pend),
        .code_o(live_code)
    );
    // Hold the code from the first wait cycle of an ident read to its completion
    wire iir_busy = avs_read_i & ack_q & (idx == uidr_pkg::IDX_IIR_FCR);
    assign code = iir_busy ? frozen_q : live_code;
    // **********************************************************************
    // DMA ready pins and registered interrupt
    // **********************************************************************
    logic rx_burst_q;
    logic tx_burst_q;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_o <= 1'b0;
            rx_burst_q <= 1'b0;
            tx_burst_q <= 1'b0;
            rx_dma_request_n_o <= 1'b1;
            tx_dma_request_n_o <= 1'b1;
        end
        else
        begin
            irq_o <= pend_any;
            if ((rx_count_i == rx_trig) || to_q)
            begin
                rx_burst_q <= 1'b1;
            end
            else if (!rx_any)
            begin
                rx_burst_q <= 1'b0;
            end
            if (tx_room)
            begin
                tx_burst_q <= 1'b1;
            end
            else if (tx_count_i == uidr_pkg::DEPTH_CNT)
            begin
                tx_burst_q <= 1'b0;
            end
            rx_dma_request_n_o <= burst ? ~(rx_burst_q & rx_any) : ~rx_any;
            tx_dma_request_n_o <= burst ? ~tx_burst_q : ~tx_empty;
        end
    end
    // **********************************************************************
    // Checks
    // **********************************************************************
    sequence s_iir_access;
        avs_read_i && !ack_q && idx == uidr_pkg::IDX_IIR_FCR ##1 avs_read_i;
    endsequence
    AST_IIR_FROZEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_iir_access |-> avs_readdata_o[5:0] == $past(live_code))
        else $error("ident read did not return code caught at access start");
    AST_NONE_CODE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pend == 7'h00 |-> live_code == uidr_pkg::CODE_NONE)
        else $error("idle code wrong");
    AST_LSR_TOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pend[0] |-> live_code == uidr_pkg::CODE_LSR)
        else $error("line status not top priority");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ##1 irq_o == $past(pend_any))
        else $error("interrupt output does not follow pending sources");
    AST_LSR_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_lsr && !err_new |=> !lsr_q)
        else $error("line status read did not clear");
    AST_THRE_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rd_iir || wr_thr) && !thre_set |=> !thre_q)
        else $error("transmit ready not cleared");
    AST_CTS_RISE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        auto_cts_i && !cts_prev_q ##1 auto_cts_i && cts_prev_q |-> cts_q)
        else $error("CTS rise not recorded");
    AST_RX_MODE0: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !burst && rx_any |=> !rx_dma_request_n_o)
        else $error("receive request not low with data held");
    AST_TX_MODE0: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !burst && !tx_empty |=> tx_dma_request_n_o)
        else $error("transmit request low while data held");
    AST_TO_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_data && !(idle_hit && bit_tick_i) |=> !to_q)
        else $error("receive buffer read did not clear timeout");
    AST_WAIT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        req && !ack_q |-> avs_waitrequest_o ##1 (!avs_waitrequest_o || !req))
        else $error("access not answered in one wait cycle");
endmodule : uidr_top

// ===== src/uidr_pkg.sv
/*
 * Constants for the UART interrupt and DMA ready block: register indices, field positions,
 * reset values, identification codes, trigger levels and the receive idle timeout.
 * Assumes one channel; the 16-deep or 64-deep FIFO variant is picked by FIFO_DEPTH.
 */
package uidr_pkg;
    // **********************************************************************
    // Register indices (byte address is four times the index)
    // **********************************************************************
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IER = 3'h1;
    localparam logic [2:0] IDX_IIR_FCR = 3'h2;
    localparam logic [2:0] IDX_LSR = 3'h5;
    localparam logic [2:0] IDX_MSR = 3'h6;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] FCR_RESET = 8'h00;
    // **********************************************************************
    // Field positions
    // **********************************************************************
    localparam int IER_RXDATA = 0;
    localparam int IER_THRE = 1;
    localparam int IER_LSR = 2;
    localparam int IER_MSR = 3;
    localparam int IER_XOFF = 5;
    localparam int IER_RTS = 6;
    localparam int IER_CTS = 7;
    localparam int FCR_FIFO_EN = 0;
    localparam int FCR_DMA_MODE = 3;
    localparam int FCR_TXTRIG_LO = 4;
    localparam int FCR_RXTRIG_LO = 6;
    // **********************************************************************
    // Identification codes, highest priority first
    // **********************************************************************
    localparam logic [5:0] CODE_LSR = 6'h06;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
    localparam logic [5:0] CODE_RXDATA = 6'h04;
    localparam logic [5:0] CODE_THRE = 6'h02;
    localparam logic [5:0] CODE_MSR = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;
    localparam int NSRC = 7;
    // **********************************************************************
    // FIFO variant and trigger levels
    // **********************************************************************
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] DEPTH_CNT = 7'(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] RXT16_0 = 7'h01;
    localparam logic [CNT_W-1:0] RXT16_1 = 7'h04;
    localparam logic [CNT_W-1:0] RXT16_2 = 7'h08;
    localparam logic [CNT_W-1:0] RXT16_3 = 7'h0e;
    localparam logic [CNT_W-1:0] RXT64_0 = 7'h08;
    localparam logic [CNT_W-1:0] RXT64_1 = 7'h10;
    localparam logic [CNT_W-1:0] RXT64_2 = 7'h38;
    localparam logic [CNT_W-1:0] RXT64_3 = 7'h3c;
    localparam logic [CNT_W-1:0] TXT64_0 = 7'h08;
    localparam logic [CNT_W-1:0] TXT64_1 = 7'h10;
    localparam logic [CNT_W-1:0] TXT64_2 = 7'h20;
    localparam logic [CNT_W-1:0] TXT64_3 = 7'h38;
    // **********************************************************************
    // Receive idle timeout: four characters plus twelve bits, in bit times
    // **********************************************************************
    localparam int CHAR_BITS = 10;
    localparam int TO_W = 8;
    localparam logic [TO_W-1:0] TIMEOUT_BITS = 8'(4 * CHAR_BITS + 12);
endpackage : uidr_pkg

// ===== src/uidr_prio.sv
/*
 * Fixed-priority encoder from the pending, enabled interrupt sources to the
 * identification code. Purely combinational; the caller freezes its output.
 */
`timescale 1ns/1ns
module uidr_prio (
    input wire logic [6:0] pend_i,
    output logic [5:0] code_o
);
    // **********************************************************************
    // Encoder, bit 0 of pend_i is the highest priority
    // **********************************************************************
    always_comb
    begin
        code_o = uidr_pkg::CODE_NONE;
        if (pend_i[0])
        begin
            code_o = uidr_pkg::CODE_LSR;
        end
        else if (pend_i[1])
        begin
            code_o = uidr_pkg::CODE_TIMEOUT;
        end
        else if (pend_i[2])
        begin
            code_o = uidr_pkg::CODE_RXDATA;
        end
        else if (pend_i[3])
        begin
            code_o = uidr_pkg::CODE_THRE;
        end
        else if (pend_i[4])
        begin
            code_o = uidr_pkg::CODE_MSR;
        end
        else if (pend_i[5])
        begin
            code_o = uidr_pkg::CODE_XOFF;
        end
        else if (pend_i[6])
        begin
            code_o = uidr_pkg::CODE_FLOW;
        end
    end
endmodule : uidr_prio

// ===== testbench/uidr_dma_model.sv
/* DMA controller stand-in for uidr_top: latches every request seen on the two ready pins.
   Assumes active-low request pins that are registered on the same clock. */
`timescale 1ns/1ns
module uidr_dma_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic rx_req_n_i,
    input wire logic tx_req_n_i,
    output logic rx_seen_o,
    output logic tx_seen_o
);
    // Sticky, so that a single-cycle request is never missed
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_seen_o <= 1'b0;
            tx_seen_o <= 1'b0;
        end
        else
        begin
            rx_seen_o <= rx_seen_o | !rx_req_n_i;
            tx_seen_o <= tx_seen_o | !tx_req_n_i;
        end
    end
endmodule : uidr_dma_model

// ===== testbench/uidr_top_test.sv
/* Self-checking bench for uidr_top: a table of interrupt cases, then hand-written cases.
   Assumes the one-wait Avalon slave of uidr_top and uidr_dma_model as the DMA side. */
`timescale 1ns/1ns
module uidr_top_test;
    typedef struct {logic [3:0] err; logic [3:0] mdm; logic [6:0] rxc;
        logic [5:0] c1; logic [4:0] clr; logic [5:0] c2;} uidr_row_t;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic tick = 1'b0;
    logic xoff = 1'b0;
    logic acts = 1'b0;
    logic cts = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [6:0] rxc = 7'h00;
    logic [6:0] txc = 7'h01;
    logic [3:0] err = 4'h0;
    logic [3:0] mdm = 4'h0;
    logic xon = 1'b0;
    logic spc = 1'b0;
    logic rxch = 1'b0;
    logic [7:0] txd;
    logic pop, push;
    logic [31:0] rdat;
    logic [7:0] fifo_control;
    logic [7:0] q;
    logic wt, irq, rx_n, tx_n, rx_seen, tx_seen;
    int n_fail = 0;
    int total_checks = 0;
    uidr_row_t rows [5];
    always #2 clk_i = ~clk_i;
    uidr_top uidr_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .rx_count_i(rxc), .tx_count_i(txc),
        .rx_data_i(wd[7:0]), .line_err_i(err), .modem_bits_i(mdm), .rx_char_i(rxch),
        .bit_tick_i(tick), .xoff_det_i(xoff), .special_det_i(spc), .xon_det_i(xon),
        .auto_cts_i(acts), .auto_rts_i(acts), .cts_i(cts), .rts_i(acts), .irq_o(irq),
        .rx_dma_request_n_o(rx_n), .tx_dma_request_n_o(tx_n), .rx_pop_o(pop),
        .tx_push_o(push), .tx_data_o(txd), .fifo_control_o(fifo_control));
    uidr_dma_model uidr_dma_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .rx_req_n_i(rx_n),
        .tx_req_n_i(tx_n), .rx_seen_o(rx_seen), .tx_seen_o(tx_seen));
    task automatic stop_test();
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask : step
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input int w, input logic [4:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int k;
        @(posedge clk_i);
        rd <= (w == 0);
        wr <= (w != 0);
        adr <= a;
        wd <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wt !== 1'b0 && k < 50);
        r = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (k == 50)
        begin
            n_fail++;
            stop_test();
        end
    endtask : bus
    initial
    begin
        rows = '{'{4'h1, 4'h0, 7'h0, uidr_pkg::CODE_LSR, 5'h14, uidr_pkg::CODE_NONE},
            '{4'h0, 4'h1, 7'h0, uidr_pkg::CODE_MSR, 5'h18, uidr_pkg::CODE_NONE},
            '{4'h0, 4'h1, 7'h1, uidr_pkg::CODE_RXDATA, 5'h00, uidr_pkg::CODE_NONE},
            '{4'h2, 4'h3, 7'h1, uidr_pkg::CODE_LSR, 5'h14, uidr_pkg::CODE_MSR},
            '{4'h0, 4'h3, 7'h0, uidr_pkg::CODE_MSR, 5'h18, uidr_pkg::CODE_NONE}};
        step(8);
        rstn_i <= 1'b1;
        step(2);
        chk("irq", 8'h00, {7'h0, irq});
        bus(0, 5'h08, 8'h00, q); chk("ident", 8'h01, q);
        bus(0, 5'h1c, 8'h00, q); chk("unmapped", 8'h00, q);
        bus(1, 5'h04, 8'hff, q);
        bus(1, 5'h08, 8'h01, q);
        foreach (rows[i])
        begin
            err <= rows[i].err;
            mdm <= rows[i].mdm;
            rxc <= rows[i].rxc;
            step(4);
            chk("irq", 8'h01, {7'h0, irq});
            bus(0, 5'h08, 8'h00, q); chk("code", {2'b11, rows[i].c1}, q);
            bus(0, rows[i].clr, 8'h00, q);
            err <= 4'h0;
            rxc <= 7'h00;
            step(4);
            bus(0, 5'h08, 8'h00, q); chk("code2", {2'b11, rows[i].c2}, q);
        end
        txc <= 7'h00;
        step(4);
        chk("txdma", 8'h00, {7'h0, tx_n});
        bus(0, 5'h08, 8'h00, q); chk("thre", {2'b11, uidr_pkg::CODE_THRE}, q);
        bus(0, 5'h08, 8'h00, q); chk("thre_clr", 8'hc1, q);
        txc <= 7'h01;
        step(2);
        txc <= 7'h00;
        step(4);
        chk("thre_irq", 8'h01, {7'h0, irq});
        bus(1, 5'h00, 8'h5a, q);
        step(1);
        chk("txdata", 8'h5a, txd);
        chk("push", 8'h01, {7'h0, push});
        bus(0, 5'h08, 8'h00, q); chk("thre_wr_clr", 8'hc1, q);
        xoff <= 1'b1;
        step(1);
        xoff <= 1'b0;
        step(3);
        bus(0, 5'h08, 8'h00, q); chk("xoff", {2'b11, uidr_pkg::CODE_XOFF}, q);
        bus(0, 5'h08, 8'h00, q); chk("xoff_clr", 8'hc1, q);
        xoff <= 1'b1;
        step(1);
        xoff <= 1'b0;
        xon <= 1'b1;
        step(1);
        xon <= 1'b0;
        step(3);
        bus(0, 5'h08, 8'h00, q); chk("xon_clr", 8'hc1, q);
        spc <= 1'b1;
        step(1);
        spc <= 1'b0;
        step(3);
        chk("spc_irq", 8'h01, {7'h0, irq});
        rxch <= 1'b1;
        step(1);
        rxch <= 1'b0;
        step(3);
        bus(0, 5'h08, 8'h00, q); chk("spc_clr", 8'hc1, q);
        acts <= 1'b1;
        step(2);
        cts <= 1'b1;
        step(6);
        bus(0, 5'h08, 8'h00, q); chk("flow", {2'b11, uidr_pkg::CODE_FLOW}, q);
        cts <= 1'b0;
        step(2);
        cts <= 1'b1;
        step(6);
        chk("flow_irq", 8'h01, {7'h0, irq});
        bus(0, 5'h18, 8'h00, q);
        bus(0, 5'h08, 8'h00, q); chk("flow_clr", 8'hc1, q);
        bus(1, 5'h08, 8'h41, q);
        rxc <= 7'h01;
        step(3);
        chk("fcr", 8'h41, fifo_control);
        chk("rxdma", 8'h00, {7'h0, rx_n});
        repeat (60)
        begin
            tick <= 1'b1;
            step(1);
            tick <= 1'b0;
            step(1);
        end
        bus(0, 5'h08, 8'h00, q); chk("tmo", {2'b11, uidr_pkg::CODE_TIMEOUT}, q);
        bus(0, 5'h00, 8'h00, q);
        step(1);
        chk("pop", 8'h01, {7'h0, pop});
        bus(0, 5'h08, 8'h00, q); chk("tmo_clr", 8'hc1, q);
        rxc <= 7'h04;
        step(4);
        bus(0, 5'h08, 8'h00, q); chk("trig4", {2'b11, uidr_pkg::CODE_RXDATA}, q);
        bus(1, 5'h08, 8'h09, q);
        rxc <= 7'h00;
        txc <= 7'h10;
        step(4);
        chk("burst_rx", 8'h01, {7'h0, rx_n});
        chk("burst_full", 8'h01, {7'h0, tx_n});
        txc <= 7'h00;
        step(4);
        chk("burst_empty", 8'h00, {7'h0, tx_n});
        chk("dma_seen", 8'h03, {6'h0, rx_seen, tx_seen});
        rstn_i <= 1'b0;
        step(2);
        chk("rst_fcr", 8'h00, fifo_control);
        chk("rst_txdma", 8'h01, {7'h0, tx_n});
        chk("rst_irq", 8'h00, {7'h0, irq});
        rstn_i <= 1'b1;
        step(2);
        bus(0, 5'h08, 8'h00, q); chk("rst_ident", 8'h01, q);
        stop_test();
    end
endmodule : uidr_top_test
